// ### core/dmem_pkg.sv
// Package for the data-memory, stack and status-word block.
// Assumes a single 125 MHz core clock shared with the sequencer and ALU.
package dmem_pkg;
  localparam int RAM_DEPTH = 64;
  localparam int RAM_AW = 6;
  localparam int PC_W = 10;
  localparam logic [5:0] BANK0_BASE = 6'h00;
  localparam logic [5:0] BANK1_BASE = 6'h18;
  localparam logic [5:0] STACK_BASE = 6'h08;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] VEC_IBF = 10'h003;
  localparam logic [PC_W-1:0] VEC_TIMER = 10'h007;
  localparam int PSW_SP_LSB = 0;
  localparam int PSW_BS_BIT = 4;
  localparam int PSW_F0_BIT = 5;
  localparam int PSW_AC_BIT = 6;
  localparam int PSW_CY_BIT = 7;
  localparam logic [7:0] PSW_RESET = 8'h00;

  // Operations requested by the sequencer, one per cycle.
  typedef enum logic [3:0] {
    OP_NONE, OP_REG_RD, OP_REG_WR, OP_IND_RD, OP_IND_WR, OP_SEL_BANK0, OP_SEL_BANK1,
    OP_CALL, OP_VEC_IBF, OP_VEC_TIMER, OP_RET, OP_RESTORING_RETURN_OP, OP_PSW_LOAD, OP_JUMP, OP_FETCH
  } op_t;

  typedef enum logic [3:0] {
    C_ACC_ZERO, C_ACC_NZ, C_ACC_BIT, C_CY, C_NCY, C_F0, C_F1, C_TF,
    C_T0, C_NT0, C_T1, C_NT1, C_NIBF, C_OBF
  } cond_t;

  typedef struct packed {
    op_t op;
    logic [2:0] reg_sel;
    logic [7:0] wdata;
    logic [PC_W-1:0] target;
    cond_t cond;
    logic [2:0] bit_sel;
  } req_t;

  typedef struct packed {
    logic f0_clr;
    logic f0_cpl;
    logic ac_wr;
    logic ac_val;
    logic cy_wr;
    logic cy_val;
  } flag_upd_t;
endpackage : dmem_pkg

// ### core/dmem_ram.sv
// A 64 x 8 single-port data RAM with registered read data.
// Assumes one access per cycle; a read and write of one cycle return the old word.
module dmem_ram
  import dmem_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [RAM_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [RAM_DEPTH];

  // Read-before-write keeps same-cycle operands intact.
  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem[addr_i];
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule // dmem_ram

// ### core/dmem_core.sv
// Data memory, return stack, program counter and status word of the core.
// Assumes the sequencer issues one request per cycle and the ALU supplies flags.
//
// Operation
// - 64 by 8 data RAM.
// - Pointers zero/one address RAM, low six bits; here the pointer comes on the request data, not from R0/R1.
// - Working registers at 0-7 or 24-31.
// - Reset selects bank zero.
// - Locations 8-23 form eight-level return stack.
// - Call/vector pushes pair, then increments pointer.
// - Stack pointer is status bits 0-2, reset zero.
// - Stack pointer wraps modulo eight silently.
// - Returns decrement pointer then load counter.
// - Restoring return reloads status bits 4-7.
// - Ten-bit counter advances on each fetch.
// - Reset clears program counter.
// - Status word copies to/from accumulator whole; the load here takes only bits 7-4 and 2-0, and bit 3 reads zero.
// - Status layout: pointer, unused, bank, flags.
// - User flag clear, complement and testable.
// - Adds update half carry; adjust reads it.
// - Carry set on accumulator overflow.
// - Jump condition sampled in state three.
// - Taken jump replaces low eight bits.
// - Full set of jump conditions.
// - Bank zero reachable indirectly; unused areas scratch.
// - Vectors to three and seven with push.
module dmem_core
  import dmem_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire req_t req_i,
  input wire logic state3_i,
  input wire logic [7:0] acc_i,
  input wire flag_upd_t flag_upd_i,
  input wire logic user_flag_one_i,
  input wire logic timer_flag_i,
  input wire logic test_in_zero_i,
  input wire logic test_in_one_i,
  input wire logic input_buffer_full_i,
  input wire logic output_buffer_full_i,
  output logic [7:0] rdata_o,
  output logic [PC_W-1:0] pc_o,
  output logic [7:0] program_status_word_o,
  output logic half_carry_flag_o,
  output logic carry_flag_o,
  output logic jump_taken_o,
  output logic busy_o
);
  typedef enum {ST_IDLE, ST_PUSH_HI, ST_POP_LO, ST_POP_DONE} seq_t;

  seq_t st_r, st_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [2:0] sp_r, sp_nxt;
  logic bank_r, bank_nxt;
  logic f0_r, f0_nxt;
  logic ac_r, ac_nxt;
  logic cy_r, cy_nxt;
  logic cond_r, cond_nxt;
  logic restore_r, restore_nxt;
  logic [1:0] pc_hi_r, pc_hi_nxt;
  logic [3:0] psw_hi_r, psw_hi_nxt;
  logic ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [7:0] program_status_word;
  logic [7:0] ptr_byte;

  // Register bank select maps a working register number to RAM.
  function automatic logic [RAM_AW-1:0] reg_addr(input logic bank, input logic [2:0] r);
    reg_addr = (bank ? BANK1_BASE : BANK0_BASE) | {3'h0, r};
  endfunction

  // Stack pair address: level n occupies 8+2n and 9+2n.
  function automatic logic [RAM_AW-1:0] pair_addr(input logic [2:0] sp, input logic odd);
    pair_addr = STACK_BASE + {2'b00, sp, odd};
  endfunction

  function automatic logic cond_eval(input req_t q, input logic [7:0] a, input logic cy,
                                     input logic f0, input logic f1, input logic tf,
                                     input logic t0, input logic t1, input logic input_buffer_full,
                                     input logic output_buffer_full);
    unique case (q.cond)
      C_ACC_ZERO: cond_eval = (a == 8'h00);
      C_ACC_NZ: cond_eval = (a != 8'h00);
      C_ACC_BIT: cond_eval = a[q.bit_sel];
      C_CY: cond_eval = cy;
      C_NCY: cond_eval = !cy;
      C_F0: cond_eval = f0;
      C_F1: cond_eval = f1;
      C_TF: cond_eval = tf;
      C_T0: cond_eval = t0;
      C_NT0: cond_eval = !t0;
      C_T1: cond_eval = t1;
      C_NT1: cond_eval = !t1;
      C_NIBF: cond_eval = !input_buffer_full;
      C_OBF: cond_eval = output_buffer_full;
      default: cond_eval = 1'b0;
    endcase
  endfunction

  // Status word is assembled from scattered flops and read whole.
  assign program_status_word = {cy_r, ac_r, f0_r, bank_r, 1'b0, sp_r};

  dmem_ram u_ram (
    .clk_sys_i(clk_sys_i),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // The pointer comes in on the request data, not from the active bank; only six bits are kept.
  always_comb begin
    ptr_byte = {2'b00, req_i.wdata[5:0]};
    st_nxt = st_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    bank_nxt = bank_r;
    f0_nxt = f0_r;
    ac_nxt = ac_r;
    cy_nxt = cy_r;
    cond_nxt = cond_r;
    restore_nxt = restore_r;
    pc_hi_nxt = pc_hi_r;
    psw_hi_nxt = psw_hi_r;
    ram_we = 1'b0;
    ram_addr = reg_addr(bank_r, req_i.reg_sel);
    ram_wdata = req_i.wdata;
    if (state3_i) begin
      cond_nxt = cond_eval(req_i, acc_i, cy_r, f0_r, user_flag_one_i, timer_flag_i,
                           test_in_zero_i, test_in_one_i, input_buffer_full_i,
                           output_buffer_full_i);
    end
    if (flag_upd_i.f0_clr) begin
      f0_nxt = 1'b0;
    end else if (flag_upd_i.f0_cpl) begin
      f0_nxt = !f0_r;
    end
    if (flag_upd_i.ac_wr) begin
      ac_nxt = flag_upd_i.ac_val;
    end
    if (flag_upd_i.cy_wr) begin
      cy_nxt = flag_upd_i.cy_val;
    end
    unique case (st_r)
      ST_IDLE: begin
        unique case (req_i.op)
          OP_REG_WR: ram_we = 1'b1;
          OP_IND_RD: ram_addr = ptr_byte[RAM_AW-1:0];
          OP_IND_WR: begin
            // Bank zero stays reachable here whatever the bank select.
            ram_addr = ptr_byte[RAM_AW-1:0];
            ram_wdata = acc_i;
            ram_we = 1'b1;
          end
          OP_SEL_BANK0: bank_nxt = 1'b0;
          OP_SEL_BANK1: bank_nxt = 1'b1;
          OP_CALL, OP_VEC_IBF, OP_VEC_TIMER: begin
            ram_addr = pair_addr(sp_r, 1'b0);
            ram_wdata = pc_r[7:0];
            ram_we = 1'b1;
            pc_hi_nxt = pc_r[9:8];
            psw_hi_nxt = program_status_word[7:4];
            pc_nxt = (req_i.op == OP_VEC_IBF) ? VEC_IBF :
                     (req_i.op == OP_VEC_TIMER) ? VEC_TIMER : req_i.target;
            st_nxt = ST_PUSH_HI;
          end
          OP_RET, OP_RESTORING_RETURN_OP: begin
            sp_nxt = sp_r - 3'h1;
            restore_nxt = (req_i.op == OP_RESTORING_RETURN_OP);
            ram_addr = pair_addr(sp_r - 3'h1, 1'b1);
            st_nxt = ST_POP_LO;
          end
          OP_PSW_LOAD: begin
            {cy_nxt, ac_nxt, f0_nxt, bank_nxt} = acc_i[7:4];
            sp_nxt = acc_i[2:0];
          end
          OP_JUMP: if (cond_r) begin
            pc_nxt = {pc_r[9:8], req_i.target[7:0]};
          end
          OP_FETCH: pc_nxt = pc_r + 10'h001;
          default: ;
        endcase
      end
      ST_PUSH_HI: begin
        ram_addr = pair_addr(sp_r, 1'b1);
        ram_wdata = {psw_hi_r, 2'b00, pc_hi_r};
        ram_we = 1'b1;
        sp_nxt = sp_r + 3'h1;
        st_nxt = ST_IDLE;
      end
      ST_POP_LO: begin
        ram_addr = pair_addr(sp_r, 1'b0);
        pc_hi_nxt = ram_rdata[1:0];
        psw_hi_nxt = ram_rdata[7:4];
        st_nxt = ST_POP_DONE;
      end
      ST_POP_DONE: begin
        pc_nxt = {pc_hi_r, ram_rdata};
        if (restore_r) begin
          {cy_nxt, ac_nxt, f0_nxt, bank_nxt} = psw_hi_r;
        end
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      pc_r <= PC_RESET;
      sp_r <= SP_RESET;
      bank_r <= PSW_RESET[PSW_BS_BIT];
      f0_r <= PSW_RESET[PSW_F0_BIT];
      ac_r <= PSW_RESET[PSW_AC_BIT];
      cy_r <= PSW_RESET[PSW_CY_BIT];
      cond_r <= 1'b0;
      restore_r <= 1'b0;
      pc_hi_r <= 2'b00;
      psw_hi_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      bank_r <= bank_nxt;
      f0_r <= f0_nxt;
      ac_r <= ac_nxt;
      cy_r <= cy_nxt;
      cond_r <= cond_nxt;
      restore_r <= restore_nxt;
      pc_hi_r <= pc_hi_nxt;
      psw_hi_r <= psw_hi_nxt;
    end
  end

  assign rdata_o = ram_rdata;
  assign pc_o = pc_r;
  assign program_status_word_o = program_status_word;
  assign half_carry_flag_o = ac_r;
  assign carry_flag_o = cy_r;
  assign jump_taken_o = cond_r;
  assign busy_o = (st_r != ST_IDLE);

  a_reset_pc: assert property (@(posedge clk_sys_i) rst_i |=> pc_r == 10'h000 && sp_r == 3'h0
    && !bank_r) else $error("reset state wrong");
  a_push_sp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_CALL) |=> ##1 sp_r == $past(sp_r, 2) + 3'h1)
    else $error("push did not advance pointer");
  a_vec_ibf: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_VEC_IBF) |=> pc_r == 10'h003)
    else $error("vector not three");
  a_pop_sp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_RET) |=> sp_r == $past(sp_r) - 3'h1)
    else $error("pop did not decrement");
  a_ret_keep: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_RET && flag_upd_i == '0) |=> ##2
    $stable(bank_r)) else $error("plain return changed bank");
  a_jump_page: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_JUMP) |=> pc_r[9:8] == $past(pc_r[9:8]))
    else $error("jump left page");
  a_fetch_inc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_FETCH) |=> pc_r == $past(pc_r) + 10'h001)
    else $error("fetch did not advance");
  a_bank1_map: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_REG_WR && bank_r) |-> ram_addr[5:3] == 3'h3)
    else $error("bank one mapping wrong");
  // The sequencer only counts on busy for its back-pressure, so its length is pinned here.
  a_vec_timer: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_VEC_TIMER) |=> pc_r == 10'h007)
    else $error("vector not seven");
  a_busy_push: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op inside {OP_CALL, OP_VEC_IBF, OP_VEC_TIMER})
    |=> busy_o ##1 !busy_o) else $error("push busy length wrong");
  a_busy_pop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op inside {OP_RET, OP_RESTORING_RETURN_OP})
    |=> busy_o ##1 busy_o ##1 !busy_o) else $error("pop busy length wrong");
  a_push_even: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_CALL)
    |-> ram_we && ram_addr == 6'h08 + {2'b00, sp_r, 1'b0}) else $error("even byte misplaced");
  a_restoring_return_op_restore: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_RESTORING_RETURN_OP)
    |=> ##2 {cy_r, ac_r, f0_r, bank_r} == $past(psw_hi_r)) else $error("status not restored");
  a_psw_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_PSW_LOAD) |=> program_status_word_o ==
    {$past(acc_i[7:4]), 1'b0, $past(acc_i[2:0])}) else $error("status load wrong");
  a_sel_bank1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_r == ST_IDLE && req_i.op == OP_SEL_BANK1) |=> bank_r)
    else $error("bank one not selected");
  a_cond_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !state3_i |=> $stable(cond_r)) else $error("condition changed off state three");
  c_call: cover property (@(posedge clk_sys_i) req_i.op == OP_CALL && st_r == ST_IDLE);
  c_restoring_return_op: cover property (@(posedge clk_sys_i) req_i.op == OP_RESTORING_RETURN_OP && st_r == ST_IDLE);
  c_wrap: cover property (@(posedge clk_sys_i) sp_r == 3'h7 ##1 sp_r == 3'h0);
  c_jump: cover property (@(posedge clk_sys_i) req_i.op == OP_JUMP && cond_r);
  c_vec_timer: cover property (@(posedge clk_sys_i) req_i.op == OP_VEC_TIMER && st_r == ST_IDLE);
endmodule // dmem_core

// ### sim/seq_model.sv
// Sequencer stand-in that hands requests to the data-memory block.
// Assumes busy is the only back-pressure and requests change just after an edge.
module seq_model
  import dmem_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic busy_i,
  output req_t req_o,
  output logic state3_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_o = '0;
    state3_o = 1'b0;
  end
  // Requests made while busy are dropped silently, so each one waits out the stack sequence.
  task automatic issue(input req_t r);
    int k;
    @(posedge clk_sys_i);
    req_o <= r;
    @(posedge clk_sys_i);
    req_o.op <= OP_NONE;
    @(negedge clk_sys_i);
    for (k = 0; k < 8 && busy_i !== 1'b0; k++) @(negedge clk_sys_i);
  endtask
  task automatic sample(input cond_t c, input logic [2:0] b);
    @(posedge clk_sys_i);
    req_o.cond <= c;
    req_o.bit_sel <= b;
    state3_o <= 1'b1;
    @(posedge clk_sys_i);
    state3_o <= 1'b0;
  endtask
endmodule // seq_model

// ### sim/data_memory_stack_status_word_tb.sv
// Self-checking bench for the data-memory, stack and status-word block.
// Assumes seq_model drives requests; a mirror of RAM, counter and flags predicts results.
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module data_memory_stack_status_word_tb;
  import dmem_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, rst_i, state3_i, busy_o, jump_taken_o, hc_o, cy_o;
  logic f1, tf, t0, t1, input_buffer_full, output_buffer_full;
  logic [7:0] acc_i, rdata_o, psw_o;
  logic [PC_W-1:0] pc_o, mpc;
  req_t req_i;
  flag_upd_t flag_upd_i;
  int n_mismatch, samples_checked, cyc, seed;
  logic [7:0] mem [RAM_DEPTH];
  logic [2:0] msp;
  logic mbs, mf0, mac, mcy;
  seq_model seq (.clk_sys_i(clk_sys_i), .busy_i(busy_o), .req_o(req_i), .state3_o(state3_i));
  dmem_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i), .state3_i(state3_i),
    .acc_i(acc_i), .flag_upd_i(flag_upd_i), .user_flag_one_i(f1), .timer_flag_i(tf),
    .test_in_zero_i(t0), .test_in_one_i(t1), .input_buffer_full_i(input_buffer_full),
    .output_buffer_full_i(output_buffer_full), .rdata_o(rdata_o), .pc_o(pc_o),
    .program_status_word_o(psw_o), .half_carry_flag_o(hc_o), .carry_flag_o(cy_o),
    .jump_taken_o(jump_taken_o), .busy_o(busy_o));
  function automatic logic [7:0] epsw();
    return {mcy, mac, mf0, mbs, 1'b0, msp};
  endfunction
  function automatic logic [5:0] rb();
    return mbs ? 6'h18 : 6'h00;
  endfunction
  task automatic op(input op_t o, input logic [2:0] rs, input logic [7:0] wd,
      input logic [9:0] tg);
    req_t r;
    logic [5:0] a;
    logic [7:0] p;
    r = '0;
    r.op = o;
    r.reg_sel = rs;
    r.wdata = wd;
    r.target = tg;
    @(posedge clk_sys_i);
    acc_i <= 8'($random(seed));
    seq.issue(r);
    a = 6'h08 + 6'(2 * msp);
    p = epsw();
    case (o)
      OP_REG_WR: mem[rb() + rs] = wd;
      OP_IND_WR: mem[wd[5:0]] = acc_i;
      OP_REG_RD: `CHK("reg", mem[rb() + rs], rdata_o)
      OP_IND_RD: `CHK("ind", mem[wd[5:0]], rdata_o)
      OP_SEL_BANK0, OP_SEL_BANK1: mbs = (o == OP_SEL_BANK1);
      OP_CALL, OP_VEC_IBF, OP_VEC_TIMER: begin
        mem[a] = mpc[7:0];
        mem[a + 6'h01] = {p[7:4], 2'b00, mpc[9:8]};
        msp++;
        mpc = o == OP_CALL ? tg : (o == OP_VEC_IBF ? 10'h003 : 10'h007);
      end
      OP_RET, OP_RESTORING_RETURN_OP: begin
        msp--;
        a = 6'h08 + 6'(2 * msp);
        mpc = {mem[a + 6'h01][1:0], mem[a]};
        if (o == OP_RESTORING_RETURN_OP) {mcy, mac, mf0, mbs} = mem[a + 6'h01][7:4];
      end
      OP_PSW_LOAD: {mcy, mac, mf0, mbs, msp} = {acc_i[7:4], acc_i[2:0]};
      OP_FETCH: mpc++;
      default: ;
    endcase
    `CHK("busy", 1'b0, busy_o)
    `CHK("pc", mpc, pc_o)
    `CHK("psw", epsw(), psw_o)
  endtask
  task automatic flags();
    flag_upd_t f;
    f = 6'($random(seed));
    @(posedge clk_sys_i);
    flag_upd_i <= f;
    @(posedge clk_sys_i);
    flag_upd_i <= '0;
    @(negedge clk_sys_i);
    if (f.f0_clr) mf0 = 1'b0;
    else if (f.f0_cpl) mf0 = ~mf0;
    if (f.ac_wr) mac = f.ac_val;
    if (f.cy_wr) mcy = f.cy_val;
    `CHK("psw", epsw(), psw_o)
    `CHK("cy", mcy, cy_o)
    `CHK("ac", mac, hc_o)
  endtask
  task automatic jmp(input cond_t c);
    req_t r;
    logic [2:0] b;
    logic [9:0] tg;
    logic tk;
    b = 3'($random(seed));
    tg = 10'($random(seed));
    @(posedge clk_sys_i);
    {f1, tf, t0, t1, input_buffer_full, output_buffer_full} <= 6'($random(seed));
    acc_i <= ($random(seed) & 1) ? 8'h00 : 8'($random(seed));
    seq.sample(c, b);
    case (c)
      C_ACC_ZERO: tk = acc_i == 8'h00;
      C_ACC_NZ: tk = acc_i != 8'h00;
      C_ACC_BIT: tk = acc_i[b];
      C_CY: tk = mcy;
      C_NCY: tk = !mcy;
      C_F0: tk = mf0;
      C_F1: tk = f1;
      C_TF: tk = tf;
      C_T0: tk = t0;
      C_NT0: tk = !t0;
      C_T1: tk = t1;
      C_NT1: tk = !t1;
      C_NIBF: tk = !input_buffer_full;
      default: tk = output_buffer_full;
    endcase
    // Inputs flip after the sample point, so a late sample picks the wrong answer.
    @(posedge clk_sys_i);
    {f1, tf, t0, t1, input_buffer_full, output_buffer_full} <= ~{f1, tf, t0, t1, input_buffer_full, output_buffer_full};
    acc_i <= ~acc_i;
    r = '0;
    r.op = OP_JUMP;
    r.target = tg;
    r.cond = c;
    r.bit_sel = b;
    seq.issue(r);
    if (tk) mpc[7:0] = tg[7:0];
    `CHK("taken", tk, jump_taken_o)
    `CHK("pc", mpc, pc_o)
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    seed = 32'h8ab3;
    rst_i = 1'b1;
    acc_i = 8'h00;
    flag_upd_i = '0;
    {f1, tf, t0, t1, input_buffer_full, output_buffer_full} = 6'h00;
    mpc = 10'h000;
    {mcy, mac, mf0, mbs, msp} = 7'h00;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("psw", 8'h00, psw_o)
    `CHK("pc", 10'h000, pc_o)
    for (int i = 0; i < 8; i++) op(OP_REG_WR, 3'(i), 8'($random(seed)), '0);
    op(OP_SEL_BANK1, '0, '0, '0);
    for (int i = 0; i < 8; i++) op(OP_REG_WR, 3'(i), 8'($random(seed)), '0);
    for (int i = 0; i < 8; i++) begin
      op(OP_REG_RD, 3'(i), '0, '0);
      op(OP_IND_RD, '0, 8'hc0 | 8'(i), '0);
      op(OP_IND_WR, '0, 8'(40 + i), '0);
      op(OP_IND_RD, '0, 8'(40 + i), '0);
    end
    op(OP_SEL_BANK0, '0, '0, '0);
    for (int i = 0; i < 8; i++) op(OP_REG_RD, 3'(i), '0, '0);
    op(OP_PSW_LOAD, '0, '0, '0);
    for (int i = 0; i < 9; i++) begin
      op(OP_FETCH, '0, '0, '0);
      op(i[0] ? OP_SEL_BANK1 : OP_SEL_BANK0, '0, '0, '0);
      op(op_t'(i == 3 ? OP_VEC_IBF : i == 6 ? OP_VEC_TIMER : OP_CALL), '0, '0,
        10'($random(seed)));
    end
    for (int i = 8; i < 24; i++) op(OP_IND_RD, '0, 8'(i), '0);
    for (int i = 0; i < 9; i++) op(i[0] ? OP_RESTORING_RETURN_OP : OP_RET, '0, '0, '0);
    repeat (16) flags();
    for (int c = 0; c < 14; c++) repeat (3) jmp(cond_t'(c));
    end_of_test();
  end
endmodule // data_memory_stack_status_word_tb
